// file: hdl/pcr_port_regs.sv
// configuration and data-out registers of one port
`timescale 1ns/100ps
`default_nettype none

module pcr_port_regs
  import port_cfg_pkg::*;
#(
  parameter logic [7:0] CTRL_MASK  = 8'hFF,
  parameter logic [7:0] DIR_MASK   = 8'hFF,
  parameter logic [7:0] DRIVE_MASK = 8'hFF,
  parameter logic [7:0] DATA_MASK  = 8'hFF
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       wrEn,
  input  wire logic [5:0] wrGroup,
  input  wire logic [7:0] wrData,
  output logic      [7:0] dataOutQ,
  output logic      [7:0] addrSelQ,
  output logic      [7:0] dirQ,
  output logic      [7:0] driveQ
);

  logic [7:0] dataOut_d;
  logic [7:0] addrSel_d;
  logic [7:0] dir_d;
  logic [7:0] drive_d;

  // =====================================================================
  // next values: a write updates only the addressed register
  // bits with no pin behind them are stored as zero so they read back 0
  always_comb begin
    dataOut_d = dataOutQ;
    addrSel_d = addrSelQ;
    dir_d     = dirQ;
    drive_d   = driveQ;
    if (wrEn) begin
      unique case (wrGroup)
        GRP_DATA_OUT:  dataOut_d = wrData & DATA_MASK;
        GRP_ADDR_SEL:  addrSel_d = wrData & CTRL_MASK;
        GRP_DIRECTION: dir_d     = wrData & DIR_MASK;
        GRP_DRIVE_SEL: drive_d   = wrData & DRIVE_MASK;
        default:       ;
      endcase
    end
  end

  // =====================================================================
  // power-up state is all zero: every pin an input in mcu io mode
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dataOutQ <= PCR_RESET;
      addrSelQ <= PCR_RESET;
      dirQ     <= PCR_RESET;
      driveQ   <= PCR_RESET;
    end else begin
      dataOutQ <= dataOut_d;
      addrSelQ <= addrSel_d;
      dirQ     <= dir_d;
      driveQ   <= drive_d;
    end
  end

endmodule : pcr_port_regs

`default_nettype wire

// file: hdl/port_cfg_pkg.sv
// shared constants for the port mode and direction control block
package port_cfg_pkg;

  // =====================================================================
  // geometry
  localparam int NUM_PORTS = 4;
  localparam int PORT_W    = 8;
  localparam int PORT_D_W  = 3;

  localparam logic [1:0] PORT_A = 2'h0;
  localparam logic [1:0] PORT_B = 2'h1;
  localparam logic [1:0] PORT_C = 2'h2;
  localparam logic [1:0] PORT_D = 2'h3;

  // =====================================================================
  // register groups inside the io register space
  // byte offset = group * 4 + port index
  localparam logic [5:0] GRP_DATA_IN   = 6'h00;
  localparam logic [5:0] GRP_DATA_OUT  = 6'h01;
  localparam logic [5:0] GRP_ADDR_SEL  = 6'h02;
  localparam logic [5:0] GRP_DIRECTION = 6'h03;
  localparam logic [5:0] GRP_DRIVE_SEL = 6'h04;
  localparam logic [5:0] GRP_ENABLE_OUT = 6'h05;

  localparam int GRP_LSB  = 2;
  localparam int PORT_LSB = 0;

  // =====================================================================
  // reset values and implemented-bit masks
  localparam logic [7:0] PCR_RESET = 8'h00;
  localparam logic [7:0] MASK_ALL  = 8'hFF;
  localparam logic [7:0] MASK_NONE = 8'h00;

  // only pins 2 and 1 exist on port D
  localparam logic [7:0] PORT_D_PINS  = 8'h06;
  // open drain on upper nibble, slew on lower nibble of ports A and B
  localparam logic [7:0] AB_OD_MASK   = 8'hF0;
  localparam logic [7:0] AB_SLEW_MASK = 8'h0F;
  // second macrocell group reaches only PC2, PC3, PC4, PC7
  localparam logic [7:0] PC_MCELL_MASK = 8'h9C;

endpackage : port_cfg_pkg

// file: hdl/port_mode_direction_control.sv
// top of the four-port mode, direction and drive control block
`timescale 1ns/100ps
`default_nettype none

module port_mode_direction_control
  import port_cfg_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  // mcu side of the io register space
  input  wire logic [7:0]            busAddr,
  input  wire logic [7:0]            busWrData,
  input  wire logic                  busWrStb,
  input  wire logic                  busRdStb,
  output logic      [7:0]            busRdData,
  // pld side
  input  wire logic [7:0]            oeTermA,
  input  wire logic [7:0]            oeTermB,
  input  wire logic [7:0]            oeTermC,
  input  wire logic [PORT_D_W-1:0]   oeTermD,
  input  wire logic [7:0]            pldOutSelA,
  input  wire logic [7:0]            pldOutSelB,
  input  wire logic [7:0]            pldOutSelC,
  input  wire logic [PORT_D_W-1:0]   pldOutSelD,
  input  wire logic [7:0]            portBGroupSecond,
  input  wire logic [7:0]            macrocell_group_first,
  input  wire logic [7:0]            macrocell_group_second,
  input  wire logic [PORT_D_W-1:0]   extChipSel,
  input  wire logic [7:0]            latchedAddr,
  // peripheral data buffer on port A
  input  wire logic                  periph_buffer_enable,
  input  wire logic                  periph_select_term_a,
  input  wire logic                  periph_select_term_b,
  input  wire logic                  periphDriveOut,
  input  wire logic [7:0]            mcuDataBus,
  output logic      [7:0]            periphRdData,
  // pins
  input  wire logic [7:0]            pinInA,
  input  wire logic [7:0]            pinInB,
  input  wire logic [7:0]            pinInC,
  input  wire logic [PORT_D_W-1:0]   pinInD,
  output logic      [7:0]            pinOutA,
  output logic      [7:0]            pinOutB,
  output logic      [7:0]            pinOutC,
  output logic      [PORT_D_W-1:0]   pinOutD,
  output logic      [7:0]            pinOeNA,
  output logic      [7:0]            pinOeNB,
  output logic      [7:0]            pinOeNC,
  output logic      [PORT_D_W-1:0]   pinOeND,
  output logic      [7:0]            fastSlewA,
  output logic      [7:0]            fastSlewB,
  output logic      [PORT_D_W-1:0]   fastSlewD
);

  // =====================================================================
  // per-port views, all padded to eight bits
  logic [NUM_PORTS-1:0][7:0] dataOutQ;
  logic [NUM_PORTS-1:0][7:0] addrSelQ;
  logic [NUM_PORTS-1:0][7:0] dirQ;
  logic [NUM_PORTS-1:0][7:0] driveQ;
  logic [NUM_PORTS-1:0][7:0] pinIn;
  logic [NUM_PORTS-1:0][7:0] oeTerm;
  logic [NUM_PORTS-1:0][7:0] pldSel;
  logic [NUM_PORTS-1:0][7:0] pldData;
  logic [NUM_PORTS-1:0][7:0] muxData;
  logic [NUM_PORTS-1:0][7:0] muxEn;
  logic [NUM_PORTS-1:0][7:0] drvEn;
  logic [NUM_PORTS-1:0][7:0] muxSlew;

  logic [5:0] wrGroup;
  logic [1:0] wrPort;
  logic       periphSelected;

  // address splits into register group and port index; a strobe held
  // high for two cycles writes twice, so the bus keeps it to one cycle
  assign wrGroup = busAddr[7:GRP_LSB];
  assign wrPort  = busAddr[GRP_LSB-1:PORT_LSB];

  // either select term opens the buffer
  assign periphSelected = periph_select_term_a || periph_select_term_b;

  // =====================================================================
  // widen port D to the common eight-bit form
  assign pinIn[PORT_A]  = pinInA;
  assign pinIn[PORT_B]  = pinInB;
  assign pinIn[PORT_C]  = pinInC;
  assign pinIn[PORT_D]  = {5'h00, pinInD};
  assign oeTerm[PORT_A] = oeTermA;
  assign oeTerm[PORT_B] = oeTermB;
  assign oeTerm[PORT_C] = oeTermC;
  assign oeTerm[PORT_D] = {5'h00, oeTermD};
  assign pldSel[PORT_A] = pldOutSelA;
  assign pldSel[PORT_B] = pldOutSelB;
  assign pldSel[PORT_C] = pldOutSelC;
  assign pldSel[PORT_D] = {5'h00, pldOutSelD};

  // =====================================================================
  // pld output sources: first group on A, first or second on B,
  // second on C, external chip selects on D
  assign pldData[PORT_A] = macrocell_group_first;
  assign pldData[PORT_B] = (portBGroupSecond & macrocell_group_second)
                         | (~portBGroupSecond & macrocell_group_first);
  assign pldData[PORT_C] = macrocell_group_second;
  assign pldData[PORT_D] = {5'h00, extChipSel};

  // =====================================================================
  // register sets; address select exists on ports A and B only
  pcr_port_regs #(
    .CTRL_MASK  (MASK_ALL),
    .DIR_MASK   (MASK_ALL),
    .DRIVE_MASK (MASK_ALL),
    .DATA_MASK  (MASK_ALL)
  ) u_regs_a (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .wrEn     (busWrStb && (wrPort == PORT_A)),
    .wrGroup  (wrGroup),
    .wrData   (busWrData),
    .dataOutQ (dataOutQ[PORT_A]),
    .addrSelQ (addrSelQ[PORT_A]),
    .dirQ     (dirQ[PORT_A]),
    .driveQ   (driveQ[PORT_A])
  );

  // port B has the same register set as port A
  pcr_port_regs #(
    .CTRL_MASK  (MASK_ALL),
    .DIR_MASK   (MASK_ALL),
    .DRIVE_MASK (MASK_ALL),
    .DATA_MASK  (MASK_ALL)
  ) u_regs_b (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .wrEn     (busWrStb && (wrPort == PORT_B)),
    .wrGroup  (wrGroup),
    .wrData   (busWrData),
    .dataOutQ (dataOutQ[PORT_B]),
    .addrSelQ (addrSelQ[PORT_B]),
    .dirQ     (dirQ[PORT_B]),
    .driveQ   (driveQ[PORT_B])
  );

  // port C: no address select, so that register stores nothing
  pcr_port_regs #(
    .CTRL_MASK  (MASK_NONE),
    .DIR_MASK   (MASK_ALL),
    .DRIVE_MASK (MASK_ALL),
    .DATA_MASK  (MASK_ALL)
  ) u_regs_c (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .wrEn     (busWrStb && (wrPort == PORT_C)),
    .wrGroup  (wrGroup),
    .wrData   (busWrData),
    .dataOutQ (dataOutQ[PORT_C]),
    .addrSelQ (addrSelQ[PORT_C]),
    .dirQ     (dirQ[PORT_C]),
    .driveQ   (driveQ[PORT_C])
  );

  // port D: only the two real pins keep any state
  pcr_port_regs #(
    .CTRL_MASK  (MASK_NONE),
    .DIR_MASK   (PORT_D_PINS),
    .DRIVE_MASK (PORT_D_PINS),
    .DATA_MASK  (PORT_D_PINS)
  ) u_regs_d (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .wrEn     (busWrStb && (wrPort == PORT_D)),
    .wrGroup  (wrGroup),
    .wrData   (busWrData),
    .dataOutQ (dataOutQ[PORT_D]),
    .addrSelQ (addrSelQ[PORT_D]),
    .dirQ     (dirQ[PORT_D]),
    .driveQ   (driveQ[PORT_D])
  );

  // =====================================================================
  // pin multiplexers, one per port with its own capabilities
  // masks are fixed per port; software cannot widen what a port offers
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    localparam logic [7:0] OD_M   = (p < 2) ? AB_OD_MASK
                                  : (p == 2) ? MASK_ALL : MASK_NONE;
    localparam logic [7:0] SLEW_M = (p < 2) ? AB_SLEW_MASK
                                  : (p == 2) ? MASK_NONE : PORT_D_PINS;
    localparam logic [7:0] PLD_M  = (p == 2) ? PC_MCELL_MASK
                                  : (p == 3) ? PORT_D_PINS : MASK_ALL;

    port_pin_mux #(
      .OD_MASK    (OD_M),
      .SLEW_MASK  (SLEW_M),
      .PLD_MASK   (PLD_M),
      .HAS_PERIPH (p == 0)
    ) u_mux (
      .dataOut        (dataOutQ[p]),
      .addrSel        (addrSelQ[p]),
      .dir            (dirQ[p]),
      .driveSel       (driveQ[p]),
      .oeTerm         (oeTerm[p]),
      .pldOutSel      (pldSel[p]),
      .pldData        (pldData[p]),
      .latchedAddr    (latchedAddr),
      .periphActive   (periph_buffer_enable),
      .periphSelected (periphSelected),
      .periphDriveOut (periphDriveOut),
      .mcuData        (mcuDataBus),
      .pinData        (muxData[p]),
      .pinEnable      (muxEn[p]),
      .drvEnable      (drvEn[p]),
      .fastSlew       (muxSlew[p])
    );
  end

  // =====================================================================
  // read mux; unmapped groups read as zero
  // enable out shows dir OR oe term, or the buffer enable on port A in peripheral mode, before open drain is applied
  logic [7:0] rdData_d;
  logic [7:0] busRdData_d;

  always_comb begin
    unique case (wrGroup)
      GRP_DATA_IN:    rdData_d = pinIn[wrPort];
      GRP_DATA_OUT:   rdData_d = dataOutQ[wrPort];
      GRP_ADDR_SEL:   rdData_d = addrSelQ[wrPort];
      GRP_DIRECTION:  rdData_d = dirQ[wrPort];
      GRP_DRIVE_SEL:  rdData_d = driveQ[wrPort];
      GRP_ENABLE_OUT: rdData_d = drvEn[wrPort];
      default:        rdData_d = 8'h00;
    endcase
    // hold the last value between read strobes
    busRdData_d = busRdStb ? rdData_d : busRdData;
  end

  // =====================================================================
  // output stage: every top output is a flop, so pins lag the
  // registers by one mclk; accepted to keep pins glitch-free
  logic [NUM_PORTS-1:0][7:0] pinOut_q;
  logic [NUM_PORTS-1:0][7:0] pinOeN_q;
  logic [NUM_PORTS-1:0][7:0] slew_q;
  logic [7:0]                periphRd_q;
  logic [7:0]                busRd_q;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pinOut_q   <= '0;
      pinOeN_q   <= '1; // all pins released at reset
      slew_q     <= '0;
      periphRd_q <= 8'h00;
      busRd_q    <= 8'h00;
    end else begin
      pinOut_q   <= muxData;
      pinOeN_q   <= ~muxEn;
      slew_q     <= muxSlew;
      periphRd_q <= pinIn[PORT_A];
      busRd_q    <= busRdData_d;
    end
  end

  // =====================================================================
  // drive the ports from the flops
  assign busRdData    = busRd_q;
  assign periphRdData = periphRd_q;
  assign pinOutA      = pinOut_q[PORT_A];
  assign pinOutB      = pinOut_q[PORT_B];
  assign pinOutC      = pinOut_q[PORT_C];
  assign pinOutD      = pinOut_q[PORT_D][PORT_D_W-1:0];
  assign pinOeNA      = pinOeN_q[PORT_A];
  assign pinOeNB      = pinOeN_q[PORT_B];
  assign pinOeNC      = pinOeN_q[PORT_C];
  assign pinOeND      = pinOeN_q[PORT_D][PORT_D_W-1:0];
  assign fastSlewA    = slew_q[PORT_A];
  assign fastSlewB    = slew_q[PORT_B];
  assign fastSlewD    = slew_q[PORT_D][PORT_D_W-1:0];

endmodule : port_mode_direction_control

`default_nettype wire

// file: hdl/port_pin_mux.sv
// per-pin source select and driver enable of one port
`timescale 1ns/100ps
`default_nettype none

module port_pin_mux
  import port_cfg_pkg::*;
#(
  parameter logic [7:0] OD_MASK   = 8'h00,
  parameter logic [7:0] SLEW_MASK = 8'h00,
  parameter logic [7:0] PLD_MASK  = 8'hFF,
  parameter bit         HAS_PERIPH = 1'b0
) (
  input  wire logic [7:0] dataOut,
  input  wire logic [7:0] addrSel,
  input  wire logic [7:0] dir,
  input  wire logic [7:0] driveSel,
  input  wire logic [7:0] oeTerm,
  input  wire logic [7:0] pldOutSel,
  input  wire logic [7:0] pldData,
  input  wire logic [7:0] latchedAddr,
  input  wire logic       periphActive,
  input  wire logic       periphSelected,
  input  wire logic       periphDriveOut,
  input  wire logic [7:0] mcuData,
  output logic      [7:0] pinData,
  output logic      [7:0] pinEnable,
  output logic      [7:0] drvEnable,
  output logic      [7:0] fastSlew
);

  logic periphMode;

  // peripheral mode takes the whole port, only where the port has it
  assign periphMode = HAS_PERIPH && periphActive;

  // =====================================================================
  // one slice per pin; bit i of each register governs pin i only
  for (genvar i = 0; i < PORT_W; i++) begin : g_pin
    logic srcBit;
    logic enBit;

    // source priority: peripheral buffer, latched address, pld, data out
    always_comb begin
      if (periphMode) begin
        srcBit = mcuData[i];
      end else if (addrSel[i]) begin
        srcBit = latchedAddr[i];
      end else if (pldOutSel[i] && PLD_MASK[i]) begin
        srcBit = pldData[i];
      end else begin
        srcBit = dataOut[i];
      end
    end

    // enable is direction OR product term; buffer needs a select term
    always_comb begin
      if (periphMode) begin
        enBit = periphSelected && periphDriveOut;
      end else begin
        enBit = dir[i] || oeTerm[i];
      end
    end

    // open drain only ever pulls low; high is left to the pull-up
    always_comb begin
      drvEnable[i] = enBit;
      if (OD_MASK[i] && driveSel[i]) begin
        pinData[i]   = 1'b0;
        pinEnable[i] = enBit && !srcBit;
      end else begin
        pinData[i]   = srcBit;
        pinEnable[i] = enBit;
      end
      fastSlew[i] = SLEW_MASK[i] && driveSel[i];
    end
  end

endmodule : port_pin_mux

`default_nettype wire

// file: tb/pin_ctrl_props.sv
// checker of register and pin behaviour of the port block
`timescale 1ns/100ps
`default_nettype none
module pin_ctrl_props
  import port_cfg_pkg::*;
(
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic [7:0] busAddr,
  input wire logic [7:0] busWrData,
  input wire logic       busWrStb,
  input wire logic       busRdStb,
  input wire logic [7:0] busRdData,
  input wire logic [7:0] oeTermA,
  input wire logic [7:0] oeTermC,
  input wire logic [7:0] pldOutSelA,
  input wire logic [7:0] pldOutSelC,
  input wire logic [7:0] macrocell_group_first,
  input wire logic [7:0] macrocell_group_second,
  input wire logic [7:0] latchedAddr,
  input wire logic       periph_buffer_enable,
  input wire logic       periph_select_term_a,
  input wire logic       periph_select_term_b,
  input wire logic       periphDriveOut,
  input wire logic [7:0] mcuDataBus,
  input wire logic [7:0] pinOutA,
  input wire logic [7:0] pinOeNA,
  input wire logic [7:0] pinOutC,
  input wire logic [7:0] pinOeNC,
  input wire logic [7:0] fastSlewA
);
  // ===================================================================
  // shadow registers, indexed by byte address
  logic [7:0] cfg_q [32];
  logic [7:0] cfg_d [32];
  logic [7:0] wrMask, rdExp, odA, srcA, enA, outA, viewA, slewA;
  logic [7:0] perEn, mskC, srcC, enC, outC;

  // no address select on C and D, only two pins on D
  assign wrMask = (busAddr[7:1] == 7'h05) ? MASK_NONE :
                  (busAddr[1:0] == PORT_D) ? PORT_D_PINS : MASK_ALL;
  always_comb begin
    cfg_d = cfg_q;
    if (busWrStb && busAddr inside {[8'h04:8'h13]}) begin
      cfg_d[busAddr[4:0]] = busWrData & wrMask;
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= '{default: PCR_RESET};
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // expected pins, computed one edge ahead since the pins are flopped
  assign rdExp = cfg_q[busAddr[4:0]];
  assign odA   = cfg_q[16] & AB_OD_MASK;
  assign srcA  = (cfg_q[8] & latchedAddr)
               | (~cfg_q[8] & pldOutSelA & macrocell_group_first)
               | (~cfg_q[8] & ~pldOutSelA & cfg_q[4]);
  assign viewA = cfg_q[12] | oeTermA;
  assign enA   = viewA & ~(odA & srcA);
  assign outA  = srcA & ~odA;
  assign slewA = cfg_q[16] & AB_SLEW_MASK;
  assign perEn = {8{(periph_select_term_a | periph_select_term_b)
                    & periphDriveOut}};
  assign mskC  = pldOutSelC & PC_MCELL_MASK;
  assign srcC  = (mskC & macrocell_group_second) | (~mskC & cfg_q[6]);
  assign enC   = (cfg_q[14] | oeTermC) & ~(cfg_q[18] & srcC);
  assign outC  = srcC & ~cfg_q[18];

  // ===================================================================
  // properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // direction write, then a cycle in plain push-pull mode
  sequence dirWriteA;
    busWrStb && busAddr == 8'h0C
      ##1 !periph_buffer_enable && odA == MASK_NONE;
  endsequence

  a_reset_floats:
    assert property ($fell(sys_rst) |-> pinOeNA == MASK_ALL
                     && pinOeNC == MASK_ALL)
    else $error("pins drive right after reset");
  a_dir_write_drives:
    assert property (dirWriteA |=> (~pinOeNA & $past(busWrData, 2))
                     == $past(busWrData, 2))
    else $error("output direction bit does not drive its pin");
  a_port_a_pins:
    assert property (!periph_buffer_enable |=> pinOeNA == ~$past(enA)
                     && pinOutA == $past(outA))
    else $error("port A pin source or enable wrong");
  a_periph_buffer:
    assert property (periph_buffer_enable && odA == MASK_NONE
                     |=> pinOeNA == ~$past(perEn) && (pinOeNA != MASK_NONE
                     || pinOutA == $past(mcuDataBus)))
    else $error("peripheral buffer enable or data wrong");
  a_port_c_pins:
    assert property (1'h1 |=> pinOeNC == ~$past(enC)
                     && pinOutC == $past(outC))
    else $error("port C pin source or enable wrong");
  a_slew_select:
    assert property (1'h1 |=> fastSlewA == $past(slewA))
    else $error("port A slew select wrong");
  a_read_config:
    assert property (busRdStb && busAddr inside {[8'h04:8'h13]}
                     |=> busRdData == $past(rdExp))
    else $error("configuration read returns wrong value");
  a_read_unmapped:
    assert property (busRdStb && busAddr > 8'h17 |=> busRdData == 8'h00)
    else $error("unmapped read not zero");
  a_enable_view:
    assert property (busRdStb && busAddr == 8'h14 && !periph_buffer_enable
                     |=> busRdData == $past(viewA))
    else $error("enable view read wrong");
  a_read_holds:
    assert property (!busRdStb |=> $stable(busRdData))
    else $error("read data changed without a read");
endmodule : pin_ctrl_props

bind port_mode_direction_control pin_ctrl_props u_props (
  .mclk, .sys_rst, .busAddr, .busWrData, .busWrStb, .busRdStb,
  .busRdData, .oeTermA, .oeTermC, .pldOutSelA, .pldOutSelC,
  .macrocell_group_first, .macrocell_group_second, .latchedAddr,
  .periph_buffer_enable, .periph_select_term_a, .periph_select_term_b,
  .periphDriveOut, .mcuDataBus, .pinOutA, .pinOeNA, .pinOutC, .pinOeNC,
  .fastSlewA
);
`default_nettype wire

// file: tb/pin_world.sv
// far side of port A: pull-ups, a peripheral and its select term
`timescale 1ns/100ps
`default_nettype none
module pin_world (
  input  wire logic       rangeHit,
  input  wire logic       programFetchStrobe,
  input  wire logic       extEn,
  input  wire logic [7:0] extVal,
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOeN,
  output logic            selTerm,
  output logic      [7:0] pinIn
);
  // select gated by fetches so code reads never open the buffer through this term
  assign selTerm = rangeHit & ~programFetchStrobe;
  // released bits show the peripheral, else the pull-up level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pinIn[i] = !pinOeN[i] ? pinOut[i] : (extEn ? extVal[i] : 1'h1);
    end
  end
endmodule : pin_world
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench of the port mode and direction control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import port_cfg_pkg::*;
  // ===================================================================
  // signals
  logic       mclk, sys_rst, busWrStb, busRdStb, periph_buffer_enable;
  logic       periph_select_term_a, periph_select_term_b, periphDriveOut;
  logic       rangeHit, programFetchStrobe, extEn;
  logic [7:0] busAddr, busWrData, busRdData, periphRdData, mcuDataBus;
  logic [7:0] oeTermA, oeTermB, oeTermC, pldOutSelA, pldOutSelB, extVal;
  logic [7:0] pldOutSelC, portBGroupSecond, latchedAddr;
  logic [7:0] macrocell_group_first, macrocell_group_second;
  logic [7:0] pinInA, pinInB, pinInC, pinOutA, pinOutB, pinOutC;
  logic [7:0] pinOeNA, pinOeNB, pinOeNC, fastSlewA, fastSlewB;
  logic [PORT_D_W-1:0] oeTermD, pldOutSelD, extChipSel, pinInD;
  logic [PORT_D_W-1:0] pinOutD, pinOeND, fastSlewD;
  int         n_errors, checks_done;

  always #25 mclk = ~mclk;

  port_mode_direction_control DUT (
    .mclk, .sys_rst, .busAddr, .busWrData, .busWrStb, .busRdStb, .busRdData,
    .oeTermA, .oeTermB, .oeTermC, .oeTermD, .pldOutSelA, .pldOutSelB,
    .pldOutSelC, .pldOutSelD, .portBGroupSecond, .macrocell_group_first,
    .macrocell_group_second, .extChipSel, .latchedAddr,
    .periph_buffer_enable, .periph_select_term_a, .periph_select_term_b,
    .periphDriveOut, .mcuDataBus, .periphRdData, .pinInA, .pinInB,
    .pinInC, .pinInD, .pinOutA, .pinOutB, .pinOutC, .pinOutD, .pinOeNA,
    .pinOeNB, .pinOeNC, .pinOeND, .fastSlewA, .fastSlewB, .fastSlewD
  );
  pin_world farSide (
    .rangeHit, .programFetchStrobe, .extEn, .extVal, .pinOut(pinOutA),
    .pinOeN(pinOeNA), .selTerm(periph_select_term_a), .pinIn(pinInA)
  );
  // other ports: a released pin rests at its pull-up level
  assign pinInB = pinOutB | pinOeNB;
  assign pinInC = pinOutC | pinOeNC;
  assign pinInD = pinOutD | pinOeND;

  // ===================================================================
  // tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    busAddr = a;
    busWrData = d;
    busWrStb = 1'h1;
    @(negedge mclk);
    busWrStb = 1'h0;
    @(negedge mclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    busAddr = a;
    busRdStb = 1'h1;
    @(negedge mclk);
    busRdStb = 1'h0;
    chk(busRdData, exp);
  endtask : rd
  // two edges: pin flop, then anything fed back from the pins
  task automatic settle;
    repeat (2) @(negedge mclk);
  endtask : settle
  task automatic applyReset;
    sys_rst = 1'h1;
    repeat (16) @(negedge mclk);
    sys_rst = 1'h0;
  endtask : applyReset
  function automatic logic [7:0] wmask(input logic [7:0] a);
    if (a == 8'h0A || a == 8'h0B) return MASK_NONE;
    return (a[1:0] == 2'h3) ? PORT_D_PINS : MASK_ALL;
  endfunction : wmask
  task automatic final_report;
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // ===================================================================
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #(20000 * 50);
    n_errors++;
    final_report();
  end

  // ===================================================================
  // tests
  initial begin
    mclk = 1'h0;
    {busWrStb, busRdStb, periph_buffer_enable, periph_select_term_b} = '0;
    {periphDriveOut, rangeHit, programFetchStrobe, extEn} = '0;
    {busAddr, busWrData, mcuDataBus, extVal, oeTermA, oeTermB} = '0;
    {oeTermC, pldOutSelA, pldOutSelB, pldOutSelC, portBGroupSecond} = '0;
    {latchedAddr, macrocell_group_first, macrocell_group_second} = '0;
    {oeTermD, pldOutSelD, extChipSel} = '0;
    n_errors = 0;
    checks_done = 0;
    applyReset();
    // reset values, read back, masks, read-only and unmapped places
    chk(pinOeNA & pinOeNC, MASK_ALL);
    for (int a = 4; a < 20; a++) rd(8'(a), PCR_RESET);
    for (int a = 4; a < 20; a++) wr(8'(a), 8'hA5 ^ 8'(a));
    for (int a = 4; a < 20; a++)
      rd(8'(a), (8'hA5 ^ 8'(a)) & wmask(8'(a)));
    wr(8'h14, 8'hFF);
    rd(8'h14, 8'hA9);
    rd(8'h40, MASK_NONE);
    chk(fastSlewB, 8'h04);
    chk(8'(pinOeND), 8'h05);
    applyReset();
    // mcu io: direction, oe term, data out, data in
    wr(8'h04, 8'h3C);
    wr(8'h0C, 8'h07);
    oeTermA = 8'h40;
    settle();
    chk(pinOeNA, 8'hB8);
    chk(pinOutA, 8'h3C);
    rd(8'h14, 8'h47);
    rd(8'h00, 8'hBC);
    // address out, only where enabled
    latchedAddr = 8'h5A;
    wr(8'h08, 8'hF0);
    chk(pinOutA, 8'h5C);
    chk(pinOeNA, 8'hB8);
    wr(8'h0C, 8'hFF);
    chk(pinOeNA, 8'h00);
    wr(8'h09, 8'hFF);
    wr(8'h0D, 8'hFF);
    chk(pinOeNB, 8'h00);
    chk(pinOutB, 8'h5A);
    // macrocell and chip select routing
    wr(8'h09, 8'h00);
    pldOutSelB = 8'hFF;
    portBGroupSecond = 8'h0F;
    macrocell_group_first = 8'hAA;
    macrocell_group_second = 8'h55;
    pldOutSelC = 8'hFF;
    pldOutSelD = 3'h7;
    extChipSel = 3'h6;
    settle();
    chk(pinOutB, 8'hA5);
    chk(pinOutC, 8'h14);
    chk(8'(pinOutD[2:1]), 8'h03);
    chk(pinOeNC, MASK_ALL);
    // open drain and slew
    wr(8'h04, 8'hF0);
    wr(8'h08, 8'h00);
    wr(8'h10, 8'hFF);
    chk(pinOeNA, 8'hF0);
    chk(pinOutA, 8'h00);
    chk(fastSlewA, 8'h0F);
    wr(8'h13, 8'hFF);
    chk(8'(fastSlewD[2:1]), 8'h03);
    wr(8'h12, 8'hFF);
    wr(8'h0E, 8'hFF);
    chk(pinOeNC, 8'h14);
    // peripheral buffer on port A
    wr(8'h10, 8'h00);
    periph_buffer_enable = 1'h1;
    mcuDataBus = 8'hC3;
    periphDriveOut = 1'h1;
    settle();
    chk(pinOeNA, MASK_ALL);
    rangeHit = 1'h1;
    settle();
    chk(pinOeNA, 8'h00);
    chk(pinOutA, 8'hC3);
    programFetchStrobe = 1'h1;
    settle();
    chk(pinOeNA, MASK_ALL);
    periph_select_term_b = 1'h1;
    settle();
    chk(pinOeNA, 8'h00);
    programFetchStrobe = 1'h0;
    periphDriveOut = 1'h0;
    extEn = 1'h1;
    extVal = 8'h96;
    settle();
    chk(periphRdData, 8'h96);
    final_report();
  end
endmodule : testbench
`default_nettype wire
